/* File: src/i2c_read_seq.sv */
/*
  two-wire bus master read sequencer with 7-bit and 10-bit addressing.
  assumes open-drain pads outside: a pin is low while its enable is high.
*/
`timescale 1ns/1ps
module i2c_read_seq
  import i2c_rd_pkg::*;
#(
  parameter int QUARTER = QUARTER_CYC,
  parameter int DEPTH   = FIFO_DEPTH
)
(
  input  wire logic        clk_sys,
  input  wire logic        rstn,
  input  wire logic        start_req,
  input  wire logic        ten_bit_mode,
  input  wire logic [9:0]  slave_addr,
  input  wire logic        stop_set,
  input  wire logic        last_byte_nak,
  input  wire logic        transmit_interrupt_enable,
  input  wire logic        data_rd,
  input  wire logic        scl_i,
  output logic             scl_o,
  output logic             scl_oe,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe,
  output logic [7:0]       rx_data,
  output logic             receive_data_full,
  output logic             ack_received,
  output logic             nack_interrupt_flag,
  output logic             stop_bit,
  output logic             busy,
  output logic             rx_irq,
  output logic             nack_irq,
  output logic             tx_irq
);

  ctl_t       ctl_ff;
  ctl_t       nxt_ctl;
  logic [1:0] rst_pipe_ff;
  logic       rst_n_sync;
  logic       stretch;
  logic       tick;
  logic       fifo_room;

  // =====================================================================
  // reset release
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      rst_pipe_ff <= 2'h0;
    end
    else
    begin
      rst_pipe_ff <= {rst_pipe_ff[0], 1'b1};
    end
  end
  assign rst_n_sync = rst_pipe_ff[1];

  // =====================================================================
  // address bytes
  function automatic logic [7:0] addr_byte(input logic [1:0] idx,
                                           input logic       ten,
                                           input logic [9:0] a);
    logic [7:0] b;
    b = {a[6:0], DIR_READ};
    if (ten)
    begin
      b = {TEN_BIT_PREFIX, a[9:8], (idx == IDX_READ) ? DIR_READ : DIR_WRITE};
    end
    return b;
  endfunction

  // =====================================================================
  // bit timing
  assign stretch = ctl_ff.scl_lvl && !ctl_ff.scl_s;
  assign tick    = (ctl_ff.qcnt == QCNT_W'(QUARTER - 1)) && !stretch;

  // =====================================================================
  // sequencer
  always_comb
  begin
    nxt_ctl            = ctl_ff;
    nxt_ctl.push.valid = 1'b0;
    nxt_ctl.sda_m      = sda_i;
    nxt_ctl.sda_s      = ctl_ff.sda_m;
    nxt_ctl.scl_m      = scl_i;
    nxt_ctl.scl_s      = ctl_ff.scl_m;
    if (stop_set)
    begin
      nxt_ctl.stop_bit = 1'b1;
    end
    if (!stretch)
    begin
      nxt_ctl.qcnt = tick ? '0 : ctl_ff.qcnt + 1'b1;
    end
    if (tick)
    begin
      nxt_ctl.ph = ctl_ff.ph + 1'b1;
    end
    case (ctl_ff.st)
      ST_IDLE:
      begin
        if (start_req)
        begin
          nxt_ctl.st       = ST_START;
          nxt_ctl.ph       = 2'h0;
          nxt_ctl.qcnt     = '0;
          nxt_ctl.byte_idx = IDX_FIRST;
          nxt_ctl.addr     = slave_addr;
          nxt_ctl.ten_bit  = ten_bit_mode;
          nxt_ctl.sda_lvl  = 1'b1;
        end
      end
      ST_START:
      begin
        if (tick)
        begin
          case (ctl_ff.ph)
            2'h0:    nxt_ctl.scl_lvl = 1'b1;
            2'h1:    nxt_ctl.sda_lvl = 1'b0;
            2'h2:    nxt_ctl.scl_lvl = 1'b0;
            default:
            begin
              nxt_ctl.sh      = addr_byte(ctl_ff.byte_idx, ctl_ff.ten_bit, ctl_ff.addr);
              nxt_ctl.sda_lvl = nxt_ctl.sh[7];
              nxt_ctl.bitcnt  = 4'h0;
              nxt_ctl.st      = ST_TX;
            end
          endcase
        end
      end
      ST_TX:
      begin
        if (tick)
        begin
          case (ctl_ff.ph)
            2'h0:    nxt_ctl.scl_lvl = 1'b1;
            2'h1:
            begin
              if (ctl_ff.bitcnt == ACK_BIT)
              begin
                nxt_ctl.ack_received = !ctl_ff.sda_s;
                nxt_ctl.nack_flag    = ctl_ff.nack_flag || ctl_ff.sda_s;
              end
            end
            2'h2:    nxt_ctl.scl_lvl = 1'b0;
            default:
            begin
              if (ctl_ff.bitcnt != ACK_BIT)
              begin
                nxt_ctl.sh      = {ctl_ff.sh[6:0], 1'b1};
                nxt_ctl.sda_lvl = ctl_ff.sh[6];
                nxt_ctl.bitcnt  = ctl_ff.bitcnt + 1'b1;
              end
              else if (!ctl_ff.ack_received)
              begin
                nxt_ctl.st = ST_HOLD;
              end
              else if (ctl_ff.ten_bit && ctl_ff.byte_idx == IDX_FIRST)
              begin
                nxt_ctl.byte_idx = IDX_SECOND;
                nxt_ctl.sh       = ctl_ff.addr[7:0];
                nxt_ctl.sda_lvl  = ctl_ff.addr[7];
                nxt_ctl.bitcnt   = 4'h0;
              end
              else if (ctl_ff.ten_bit && ctl_ff.byte_idx == IDX_SECOND)
              begin
                nxt_ctl.byte_idx = IDX_READ;
                nxt_ctl.st       = ST_START;
                nxt_ctl.sda_lvl  = 1'b1;
              end
              else
              begin
                nxt_ctl.st      = ST_WAIT;
                nxt_ctl.sda_lvl = 1'b1;
              end
            end
          endcase
        end
      end
      ST_WAIT:
      begin
        if (fifo_room)
        begin
          nxt_ctl.st     = ST_RX;
          nxt_ctl.ph     = 2'h0;
          nxt_ctl.qcnt   = '0;
          nxt_ctl.bitcnt = 4'h0;
        end
      end
      ST_RX:
      begin
        if (tick)
        begin
          case (ctl_ff.ph)
            2'h0:    nxt_ctl.scl_lvl = 1'b1;
            2'h1:
            begin
              if (ctl_ff.bitcnt != ACK_BIT)
              begin
                nxt_ctl.sh = {ctl_ff.sh[6:0], ctl_ff.sda_s};
              end
            end
            2'h2:    nxt_ctl.scl_lvl = 1'b0;
            default:
            begin
              if (ctl_ff.bitcnt == LAST_DATA_BIT)
              begin
                nxt_ctl.push.valid = 1'b1;
                nxt_ctl.push.data  = ctl_ff.sh;
                nxt_ctl.bitcnt     = ACK_BIT;
                nxt_ctl.nak_sent   = last_byte_nak;
                nxt_ctl.sda_lvl    = last_byte_nak;
              end
              else if (ctl_ff.bitcnt == ACK_BIT)
              begin
                nxt_ctl.sda_lvl = 1'b1;
                if (ctl_ff.nak_sent)
                begin
                  nxt_ctl.nack_flag = 1'b1;
                  nxt_ctl.st        = ST_HOLD;
                end
                else
                begin
                  nxt_ctl.st = ST_WAIT;
                end
              end
              else
              begin
                nxt_ctl.bitcnt = ctl_ff.bitcnt + 1'b1;
              end
            end
          endcase
        end
      end
      ST_HOLD:
      begin
        if (ctl_ff.stop_bit)
        begin
          nxt_ctl.st      = ST_STOP;
          nxt_ctl.ph      = 2'h0;
          nxt_ctl.qcnt    = '0;
          nxt_ctl.sda_lvl = 1'b0;
        end
      end
      ST_STOP:
      begin
        if (tick)
        begin
          case (ctl_ff.ph)
            2'h0:    nxt_ctl.scl_lvl = 1'b1;
            2'h1:    nxt_ctl.sda_lvl = 1'b1;
            2'h2:    nxt_ctl.sda_lvl = 1'b1;
            default:
            begin
              nxt_ctl.stop_bit  = stop_set;
              nxt_ctl.nack_flag = 1'b0;
              nxt_ctl.st        = ST_IDLE;
            end
          endcase
        end
      end
      default: nxt_ctl = CTL_RESET;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n_sync)
  begin
    if (!rst_n_sync)
    begin
      ctl_ff <= CTL_RESET;
    end
    else
    begin
      ctl_ff <= nxt_ctl;
    end
  end

  // =====================================================================
  // receive buffer
  rx_fifo #(
    .WIDTH (DATA_W),
    .DEPTH (DEPTH)
  ) u_rx_fifo (
    .clk_sys   (clk_sys),
    .rst_n     (rst_n_sync),
    .in_valid  (ctl_ff.push.valid),
    .in_ready  (fifo_room),
    .in_data   (ctl_ff.push.data),
    .out_valid (receive_data_full),
    .out_ready (data_rd),
    .out_data  (rx_data)
  );

  // =====================================================================
  // outputs
  assign scl_o               = 1'b0;
  assign scl_oe              = !ctl_ff.scl_lvl;
  assign sda_o               = 1'b0;
  assign sda_oe              = !ctl_ff.sda_lvl;
  assign ack_received        = ctl_ff.ack_received;
  assign nack_interrupt_flag = ctl_ff.nack_flag;
  assign stop_bit            = ctl_ff.stop_bit;
  assign busy                = (ctl_ff.st != ST_IDLE);
  assign rx_irq              = receive_data_full;
  assign nack_irq            = ctl_ff.nack_flag;
  assign tx_irq              = transmit_interrupt_enable && (ctl_ff.st == ST_IDLE);

  // =====================================================================
  // checks
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n_sync);

  a_start_first: assert property ((ctl_ff.st == ST_IDLE && start_req) |=>
    (ctl_ff.st == ST_START && ctl_ff.sda_lvl && ctl_ff.ph == 2'h0))
    else $error("start request did not open a start condition");
  a_start_edge: assert property (($fell(ctl_ff.sda_lvl) && ctl_ff.scl_lvl) |->
    (ctl_ff.st == ST_START))
    else $error("data fell with clock high outside start");
  a_read_dir: assert property ((ctl_ff.st == ST_TX && ctl_ff.ph == 2'h1 &&
    ctl_ff.bitcnt == LAST_DATA_BIT && (!ctl_ff.ten_bit || ctl_ff.byte_idx == IDX_READ)) |->
    (ctl_ff.sda_lvl == DIR_READ && ctl_ff.scl_lvl))
    else $error("read direction bit not sent");
  a_ack_seen: assert property ((tick && ctl_ff.st == ST_TX && ctl_ff.ph == 2'h1 &&
    ctl_ff.bitcnt == ACK_BIT && !ctl_ff.sda_s) |=> ctl_ff.ack_received)
    else $error("slave ack not recorded");
  a_nack_flags: assert property ((tick && ctl_ff.st == ST_TX && ctl_ff.ph == 2'h1 &&
    ctl_ff.bitcnt == ACK_BIT && ctl_ff.sda_s) |=> (ctl_ff.nack_flag && !ctl_ff.ack_received))
    else $error("address nack flags wrong");
  a_stop_clear: assert property ((tick && ctl_ff.st == ST_STOP && ctl_ff.ph == 2'h3 &&
    !stop_set) |=> (!ctl_ff.stop_bit && !ctl_ff.nack_flag && ctl_ff.st == ST_IDLE))
    else $error("stop did not clear its flags");
  a_hold_stop: assert property ((ctl_ff.st == ST_HOLD && !ctl_ff.stop_bit && !stop_set)
    |=> (ctl_ff.st == ST_HOLD && !ctl_ff.scl_lvl))
    else $error("left hold without stop");
  a_ack_out: assert property ((ctl_ff.st == ST_RX && ctl_ff.bitcnt == ACK_BIT &&
    ctl_ff.ph == 2'h1) |-> (ctl_ff.sda_lvl == ctl_ff.nak_sent))
    else $error("wrong ack level after data byte");
  a_push_full: assert property (ctl_ff.push.valid |=> receive_data_full)
    else $error("received byte did not set full flag");
  a_final_nack: assert property ((tick && ctl_ff.st == ST_RX && ctl_ff.ph == 2'h3 &&
    ctl_ff.bitcnt == ACK_BIT && ctl_ff.nak_sent) |=> (ctl_ff.nack_flag && ctl_ff.st == ST_HOLD))
    else $error("final nack did not raise flag");
  a_prefix_byte: assert property ((tick && ctl_ff.st == ST_START && ctl_ff.ph == 2'h3 &&
    ctl_ff.ten_bit) |=> (ctl_ff.sh[7:3] == TEN_BIT_PREFIX && ctl_ff.sh[2:1] == ctl_ff.addr[9:8]))
    else $error("ten-bit prefix wrong");
  a_dir_write: assert property ((tick && ctl_ff.st == ST_START && ctl_ff.ph == 2'h3 &&
    ctl_ff.ten_bit && ctl_ff.byte_idx == IDX_FIRST) |=> (ctl_ff.sh[0] == DIR_WRITE))
    else $error("first ten-bit byte not write");
  a_restart_order: assert property ((tick && ctl_ff.st == ST_TX && ctl_ff.ph == 2'h3 &&
    ctl_ff.bitcnt == ACK_BIT && ctl_ff.ack_received && ctl_ff.ten_bit &&
    ctl_ff.byte_idx == IDX_SECOND) |=> (ctl_ff.st == ST_START && ctl_ff.byte_idx == IDX_READ))
    else $error("no repeated start after low address byte");
  a_hold_wait: assert property ((ctl_ff.st == ST_WAIT && !fifo_room) |=>
    (ctl_ff.st == ST_WAIT && !ctl_ff.scl_lvl))
    else $error("clock released with no room");

  c_byte_in: cover property (ctl_ff.push.valid);
  c_ten_bit_read: cover property (ctl_ff.st == ST_TX && ctl_ff.byte_idx == IDX_READ);
  c_stall: cover property (ctl_ff.st == ST_WAIT && !fifo_room);
  c_stop_done: cover property (ctl_ff.st == ST_STOP ##1 ctl_ff.st == ST_IDLE);
endmodule

/* File: src/i2c_rd_pkg.sv */
/*
  constants, state encodings and carrier types for the two-wire read sequencer.
  assumes a single system clock of 100 MHz and open-drain pads outside.
*/
package i2c_rd_pkg;

  // =====================================================================
  // timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int SCL_PERIOD_NS = 10000;
  localparam int QUARTER_CYC   = SCL_PERIOD_NS / (4 * CLK_PERIOD_NS);
  localparam int QCNT_W        = 9;

  // =====================================================================
  // data path
  localparam int DATA_W     = 8;
  localparam int FIFO_DEPTH = 16;

  // =====================================================================
  // address framing
  localparam logic [4:0] TEN_BIT_PREFIX = 5'h1e;
  localparam logic       DIR_WRITE      = 1'h0;
  localparam logic       DIR_READ       = 1'h1;
  localparam logic [3:0] LAST_DATA_BIT  = 4'h7;
  localparam logic [3:0] ACK_BIT        = 4'h8;
  localparam logic [1:0] IDX_FIRST      = 2'h0;
  localparam logic [1:0] IDX_SECOND     = 2'h1;
  localparam logic [1:0] IDX_READ       = 2'h2;

  // =====================================================================
  // types
  typedef enum logic [2:0]
  {
    ST_IDLE  = 3'h0,
    ST_START = 3'h1,
    ST_TX    = 3'h3,
    ST_WAIT  = 3'h2,
    ST_RX    = 3'h6,
    ST_HOLD  = 3'h7,
    ST_STOP  = 3'h5
  } seq_state_t;

  typedef struct packed
  {
    logic              valid;
    logic [DATA_W-1:0] data;
  } rx_push_t;

  typedef struct packed
  {
    seq_state_t        st;
    logic [QCNT_W-1:0] qcnt;
    logic [1:0]        ph;
    logic [3:0]        bitcnt;
    logic [1:0]        byte_idx;
    logic [7:0]        sh;
    logic [9:0]        addr;
    logic              ten_bit;
    logic              scl_lvl;
    logic              sda_lvl;
    logic              ack_received;
    logic              nack_flag;
    logic              stop_bit;
    logic              nak_sent;
    rx_push_t          push;
    logic              sda_m;
    logic              sda_s;
    logic              scl_m;
    logic              scl_s;
  } ctl_t;

  // =====================================================================
  // reset values
  localparam ctl_t CTL_RESET = '{st: ST_IDLE, scl_lvl: 1'h1, sda_lvl: 1'h1, sda_m: 1'h1,
                                 sda_s: 1'h1, scl_m: 1'h1, scl_s: 1'h1, default: '0};

endpackage

/* File: src/rx_fifo.sv */
/*
  small first-in first-out buffer with valid/ready on both sides.
  assumes one clock and an active-low reset already synchronised.
*/
`timescale 1ns/1ps
module rx_fifo
  import i2c_rd_pkg::*;
#(
  parameter int WIDTH = DATA_W,
  parameter int DEPTH = FIFO_DEPTH
)
(
  input  wire logic             clk_sys,
  input  wire logic             rst_n,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed
  {
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0]   count;
  } fifo_state_t;

  fifo_state_t      fst_ff;
  fifo_state_t      nxt_fst;
  logic [WIDTH-1:0] mem [DEPTH];
  logic             do_wr;
  logic             do_rd;

  // =====================================================================
  // flags
  assign in_ready  = (fst_ff.count != (AW+1)'(DEPTH));
  assign out_valid = (fst_ff.count != '0);
  assign out_data  = mem[fst_ff.rd_ptr];
  assign do_wr     = in_valid && in_ready;
  assign do_rd     = out_valid && out_ready;

  always_comb
  begin
    nxt_fst = fst_ff;
    if (do_wr)
    begin
      nxt_fst.wr_ptr = (fst_ff.wr_ptr == AW'(DEPTH - 1)) ? '0 : fst_ff.wr_ptr + 1'b1;
    end
    if (do_rd)
    begin
      nxt_fst.rd_ptr = (fst_ff.rd_ptr == AW'(DEPTH - 1)) ? '0 : fst_ff.rd_ptr + 1'b1;
    end
    case ({do_wr, do_rd})
      2'h2:    nxt_fst.count = fst_ff.count + 1'b1;
      2'h1:    nxt_fst.count = fst_ff.count - 1'b1;
      default: nxt_fst.count = fst_ff.count;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      fst_ff <= '0;
    end
    else
    begin
      fst_ff <= nxt_fst;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (do_wr)
    begin
      mem[fst_ff.wr_ptr] <= in_data;
    end
  end

  // =====================================================================
  // checks
  a_read_clears: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (do_rd && !do_wr && fst_ff.count == 1) |=> !out_valid)
    else $error("read of last byte did not clear full flag");
  a_no_overwrite: assert property (@(posedge clk_sys) disable iff (!rst_n)
    in_valid |-> in_ready)
    else $error("byte pushed into a full buffer");
endmodule

/* File: testbench/i2c_slave_model.sv */
/*
  behavioural slave on the two-wire bus: acks its address, sends bytes 5a^index.
  assumes the bench makes wire levels with pull-ups from all pull enables.
*/
`timescale 1ns/1ps
module i2c_slave_model
  import i2c_rd_pkg::*;
#(
  parameter logic [6:0] ADDR7  = 7'h55,
  parameter logic [9:0] ADDR10 = 10'h2b7
)
(
  input  wire logic scl,
  input  wire logic sda,
  input  wire logic stretch,
  output logic      scl_pull,
  output logic      sda_pull
);
  // =====================================================================
  // state and logs
  logic [7:0] sh, out_b;
  logic [7:0] rx_log [0:3];
  logic       mack [0:31];
  logic       tx_mode = 1'b0, acked = 1'b0, go_tx = 1'b0, prev_pw = 1'b0, idle = 1'b1;
  int         cnt = 0, n_rx = 0, n_tx = 0, n_start = 0, n_stop = 0;
  initial scl_pull = 1'b0;
  initial sda_pull = 1'b0;
  // =====================================================================
  // start and stop
  always @(negedge sda)
    if (scl === 1'b1)
    begin
      if (idle)
        {n_rx, n_tx, n_start, n_stop} = '0;
      idle = 1'b0;
      n_start++;
      cnt = 0;
      tx_mode = 1'b0;
    end
  always @(posedge sda)
    if (scl === 1'b1)
    begin
      n_stop++;
      idle = 1'b1;
    end
  // =====================================================================
  // bit sampling on the rising clock
  always @(posedge scl)
  begin
    if (cnt < 8 && !tx_mode)
      sh = {sh[6:0], sda};
    if (cnt == 8 && tx_mode)
    begin
      mack[n_tx] = !sda;
      n_tx++;
    end
    cnt++;
  end
  // =====================================================================
  // answers while the clock is low, optional stretch
  always @(negedge scl)
  begin
    #20;
    if (cnt == 8 && !tx_mode)
    begin
      rx_log[n_rx & 3] = sh;
      n_rx++;
      go_tx = sh[0] == DIR_READ && (sh[7:1] == ADDR7 || sh[7:1] == {TEN_BIT_PREFIX, ADDR10[9:8]});
      acked = go_tx || sh == {TEN_BIT_PREFIX, ADDR10[9:8], DIR_WRITE} ||
              (prev_pw && sh == ADDR10[7:0]);
      prev_pw = sh == {TEN_BIT_PREFIX, ADDR10[9:8], DIR_WRITE};
      sda_pull = acked;
    end
    else if (cnt == 9)
    begin
      cnt = 0;
      tx_mode = tx_mode ? mack[n_tx-1] : go_tx;
      out_b = 8'h5a ^ 8'(n_tx);
      sda_pull = tx_mode && !out_b[7];
    end
    else
      sda_pull = tx_mode && cnt < 8 && !out_b[7-cnt];
    if (stretch)
    begin
      scl_pull = 1'b1;
      #130;
      scl_pull = 1'b0;
    end
  end
endmodule

/* File: testbench/tb_top.sv */
/*
  self-checking bench for the read sequencer, slave model on the far side.
  assumes open-drain wires with pull-ups; QUARTER of 4 gives 40 ns quarters, 180 ns bits with the two-cycle clock sync stall.
*/
`timescale 1ns/1ps
module tb_top
  import i2c_rd_pkg::*;
();
  logic       clk_sys = 1'b0, rstn = 1'b0, start_req = 1'b0, ten_bit_mode = 1'b0;
  logic [9:0] slave_addr = 10'h000;
  logic       stop_set = 1'b0, last_byte_nak = 1'b0, txie = 1'b1, data_rd = 1'b0;
  logic       stretch = 1'b0, scl_o, scl_oe, sda_o, sda_oe, rdf, ack_received, nack_flag;
  logic       stop_bit, busy, rx_irq, nack_irq, tx_irq, scl_pull, sda_pull;
  logic [7:0] rx_data;
  wire        scl_w = !scl_oe && !scl_pull;
  wire        sda_w = !sda_oe && !sda_pull;
  int         fails = 0, compares = 0, cycles = 0;

  i2c_read_seq #(.QUARTER(4), .DEPTH(16)) dut_u (
    .clk_sys(clk_sys), .rstn(rstn), .start_req(start_req), .ten_bit_mode(ten_bit_mode),
    .slave_addr(slave_addr), .stop_set(stop_set), .last_byte_nak(last_byte_nak),
    .transmit_interrupt_enable(txie), .data_rd(data_rd), .scl_i(scl_w), .scl_o(scl_o),
    .scl_oe(scl_oe), .sda_i(sda_w), .sda_o(sda_o), .sda_oe(sda_oe), .rx_data(rx_data),
    .receive_data_full(rdf), .ack_received(ack_received), .nack_interrupt_flag(nack_flag),
    .stop_bit(stop_bit), .busy(busy), .rx_irq(rx_irq), .nack_irq(nack_irq), .tx_irq(tx_irq));
  i2c_slave_model #(.ADDR7(7'h55), .ADDR10(10'h2b7)) slave_u (
    .scl(scl_w), .sda(sda_w), .stretch(stretch), .scl_pull(scl_pull), .sda_pull(sda_pull));

  // =====================================================================
  // clock, timeout, helpers
  initial forever #5 clk_sys = !clk_sys;
  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 30000)
    begin
      fails++;
      report_and_stop();
    end
  end
  task automatic report_and_stop();
    if (fails == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk_bit(input string nm, input logic e, input logic g);
    compares++;
    if (g !== e)
    begin
      fails++;
      $display("Error %s expected %b seen %b", nm, e, g);
    end
  endtask
  task automatic chk_byte(input string nm, input logic [7:0] e, input logic [7:0] g);
    compares++;
    if (g !== e)
    begin
      fails++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic begin_read(input logic ten, input logic [9:0] a);
    @(posedge clk_sys);
    ten_bit_mode <= ten;
    slave_addr <= a;
    start_req <= 1'b1;
    @(posedge clk_sys);
    start_req <= 1'b0;
    for (int i = 0; i < 100 && sda_w !== 1'b0; i++) @(negedge clk_sys);
    chk_bit("busy", 1'b1, busy);
    chk_bit("scl at start", 1'b1, scl_w);
  endtask
  task automatic finish_stop();
    @(posedge clk_sys);
    stop_set <= 1'b1;
    @(posedge clk_sys);
    stop_set <= 1'b0;
    @(negedge clk_sys);
    chk_bit("stop_bit set", 1'b1, stop_bit);
    for (int i = 0; i < 200 && busy !== 1'b0; i++) @(negedge clk_sys);
    chk_bit("stop_bit", 1'b0, stop_bit);
    chk_bit("nack flag", 1'b0, nack_flag);
    chk_byte("stops", 8'h01, 8'(slave_u.n_stop));
  endtask
  task automatic drain(input int n);
    for (int k = 0; k < n; k++)
    begin
      for (int i = 0; i < 4000 && rdf !== 1'b1; i++) @(negedge clk_sys);
      chk_byte("rx_data", 8'h5a ^ 8'(k), rx_data);
      chk_bit("rx_irq", 1'b1, rx_irq);
      @(posedge clk_sys);
      data_rd <= 1'b1;
      if (k + 2 == n) last_byte_nak <= 1'b1;
      @(posedge clk_sys);
      data_rd <= 1'b0;
      @(negedge clk_sys);
      if (!stretch) chk_bit("rdf cleared", 1'b0, rdf);
    end
    for (int i = 0; i < 500 && nack_flag !== 1'b1; i++) @(negedge clk_sys);
    chk_bit("nack_irq", 1'b1, nack_irq);
    chk_bit("ack_received", 1'b1, ack_received);
    for (int j = 0; j < n; j++) chk_bit("master ack", 1'(j != n - 1), slave_u.mack[j]);
    finish_stop();
    @(posedge clk_sys);
    last_byte_nak <= 1'b0;
  endtask

  // =====================================================================
  // scenarios
  task automatic sc_seven();
    begin_read(1'b0, 10'h055);
    drain(3);
    chk_byte("address byte", {7'h55, DIR_READ}, slave_u.rx_log[0]);
  endtask
  task automatic sc_ten();
    begin_read(1'b1, 10'h2b7);
    drain(2);
    chk_byte("prefix w", {TEN_BIT_PREFIX, 2'h2, DIR_WRITE}, slave_u.rx_log[0]);
    chk_byte("low byte", 8'hb7, slave_u.rx_log[1]);
    chk_byte("prefix r", {TEN_BIT_PREFIX, 2'h2, DIR_READ}, slave_u.rx_log[2]);
    chk_byte("starts", 8'h02, 8'(slave_u.n_start));
  endtask
  task automatic sc_nack();
    begin_read(1'b0, 10'h012);
    for (int i = 0; i < 500 && nack_flag !== 1'b1; i++) @(negedge clk_sys);
    chk_bit("nack_irq", 1'b1, nack_irq);
    chk_bit("ack cleared", 1'b0, ack_received);
    chk_bit("held busy", 1'b1, busy);
    @(posedge clk_sys);
    txie <= 1'b0;
    finish_stop();
    chk_bit("tx_irq off", 1'b0, tx_irq);
    @(posedge clk_sys);
    txie <= 1'b1;
    repeat (2) @(negedge clk_sys);
    chk_bit("tx_irq idle", 1'b1, tx_irq);
  endtask
  task automatic sc_full();
    stretch <= 1'b1;
    begin_read(1'b0, 10'h055);
    for (int i = 0; i < 6000 && slave_u.n_tx != 16; i++) @(negedge clk_sys);
    repeat (300) @(negedge clk_sys);
    chk_byte("bytes before stall", 8'h10, 8'(slave_u.n_tx));
    chk_bit("scl held low", 1'b0, scl_w);
    chk_bit("rdf full", 1'b1, rdf);
    @(posedge clk_sys);
    last_byte_nak <= 1'b1;
    drain(17);
    stretch <= 1'b0;
  endtask

  initial
  begin
    repeat (2) @(posedge clk_sys);
    rstn <= 1'b1;
    repeat (4) @(negedge clk_sys);
    chk_bit("idle scl_oe", 1'b0, scl_oe);
    chk_bit("idle sda_oe", 1'b0, sda_oe);
    chk_bit("scl_o", 1'b0, scl_o);
    chk_bit("sda_o", 1'b0, sda_o);
    chk_bit("idle ack", 1'b0, ack_received);
    chk_bit("idle nack", 1'b0, nack_flag);
    chk_bit("idle rdf", 1'b0, rdf);
    sc_seven();
    sc_nack();
    sc_ten();
    sc_full();
    report_and_stop();
  end
endmodule
